// file: src/afe_pll_clamp_config_regs.sv
`timescale 1ns/1ps
// Function
// (R1) offset low register: two LSBs in bits 7:6
// (R2) compensation off: upper offset byte drives DAC
// (R3) compensation on: offset word adds to samples
// (R4) 14-bit line length adopted on low write
// (R5) six-bit phase selects sample instant, 1.56% steps
// (R6) pre-hold lines before vsync freeze pll
// (R7) post-hold lines after vsync keep holding
// (R8) lock-edge bit: 0 trailing, 1 leading hsync
// (R9) clock-invert enable gates inversion pin
// (R10) hold source: internal window or external pin
// (R11) hold polarity: 0 active high, 1 low
// (R12) clock source: internal pll or external pin
// (R13) 14-bit clamp start after hsync trailing edge
// (R14) clamp width in pixels, ac-coupled only
// (R15) clamp width zero never connects clamp
// (R16) 0x80 high, zero low is mid/zero
// (R17) during hold pll ignores hsync edges
// (R18) host writes line-length high before low
module afe_pll_clamp_config_regs
   import afe_cfg_pkg::*;
#(
   parameter int LINE_W = 14,   // line length / clamp start width
   parameter int FRAME_W = 12   // lines-per-frame counter width
) (
   input wire logic clk_sys, // system clock, 100 MHz
   input wire logic rst_n, // async reset, active low
   // classic wishbone slave
   input wire logic wb_cyc_i, // bus cycle
   input wire logic wb_stb_i, // strobe
   input wire logic wb_we_i, // write enable
   input wire logic [9:0] wb_adr_i, // byte address
   input wire logic [3:0] wb_sel_i, // byte selects
   input wire logic [31:0] wb_dat_i, // write data
   output logic [31:0] wb_dat_o, // read data
   output logic wb_ack_o, // acknowledge
   // pins
   input wire afe_cfg_pkg::sync_pins_t pins_i, // asynchronous pins
   // sample path
   input wire logic [9:0] sample_i [3], // converted samples r,g,b
   output logic [9:0] sample_o [3], // samples after offset
   // analog controls
   output logic [7:0] offset_dac_o [3], // offset dac codes r,g,b
   output logic offset_digital_o, // offset used digitally
   output logic [LINE_W-1:0] line_length_o, // pll line length
   output logic [5:0] sample_phase_o, // sampling phase code
   output logic pll_hold_o, // pll holding frequency
   output logic pll_ref_o, // pll reference edge pulse
   output logic clock_invert_o, // pixel clock inverted
   output logic external_pixel_clock_sel_o, // clock from external pin
   output logic clamp_connect_o, // clamp dac on input
   output logic black_avg_start_o // averaging start pulse
);
   import afe_cfg_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // register storage
   logic [7:0] ofs_hi_q [3]; // offset high bytes
   logic [7:0] ofs_lo_q [3]; // offset low registers
   logic [7:0] len_hi_q; // line length high
   logic [7:0] len_lo_q; // line length low
   logic [LINE_W-1:0] len_act_q; // adopted line length
   logic [7:0] phase_q; // sampling phase
   logic [7:0] pre_hold_q; // lines held before vsync
   logic [7:0] post_hold_q; // lines held after vsync
   logic [7:0] pll_opt_q; // pll options
   logic [7:0] clamp_hi_q; // clamp start high
   logic [7:0] clamp_lo_q; // clamp start low
   logic [7:0] clamp_width_q; // clamp width
   logic [7:0] comp_ctrl_q; // compensation control
   logic [7:0] input_cfg_q; // input coupling
   logic ack_q; // bus acknowledge
   logic [7:0] idx; // register index
   logic wr_stb; // write takes effect this edge
   logic [7:0] wbyte; // written low byte

   // returns the 10-bit offset word of a channel
   function automatic offset_word_t ofs_word(input logic [7:0] hi, input logic [7:0] lo);
      offset_word_t w;
      w.hi = hi;
      w.lo = lo[OFS_LO_MSB:OFS_LO_LSB];     // R1
      return w;
   endfunction

   // joins a six-bit high half and a low byte into a 14-bit value
   function automatic logic [LINE_W-1:0] join14(input logic [7:0] hi, input logic [7:0] lo);
      return LINE_W'({hi[HI6_MSB:0], lo});
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // bus handshake: one wait state, ack for one cycle, unmapped reads zero
   assign idx = wb_adr_i[9:2];
   // a write lands at the edge where the master samples ack high
   assign wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && ack_q && wb_sel_i[0];
   assign wbyte = wb_dat_i[7:0];

   // ack follows the request by one cycle and drops the next
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
      end
   end
   assign wb_ack_o = ack_q;

   // offset registers, three channels
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         for (int c = 0; c < 3; c++) begin
            ofs_hi_q[c] <= RST_OFS_HI;   // R16
            ofs_lo_q[c] <= RST_OFS_LO;
         end
      end else if (wr_stb) begin
         for (int c = 0; c < 3; c++) begin
            if (idx == IDX_RED_OFS_HI + 8'(2 * c)) begin
               ofs_hi_q[c] <= wbyte;
            end else if (idx == IDX_RED_OFS_LO + 8'(2 * c)) begin
               // unused low bits are not stored
               ofs_lo_q[c] <= {wbyte[OFS_LO_MSB:OFS_LO_LSB], 6'h00};   // R1
            end
         end
      end
   end

   // line length: the pll sees the pair only when the low half lands
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         len_hi_q <= RST_LINE_LEN_HI;
         len_lo_q <= RST_LINE_LEN_LO;
         len_act_q <= join14(RST_LINE_LEN_HI, RST_LINE_LEN_LO);
      end else if (wr_stb) begin
         if (idx == IDX_LINE_LEN_HI) begin
            len_hi_q <= {2'b00, wbyte[HI6_MSB:0]};
         end else if (idx == IDX_LINE_LEN_LO) begin
            len_lo_q <= wbyte;
            // high half written earlier by the host is combined here
            len_act_q <= join14(len_hi_q, wbyte);   // R4 R18
         end
      end
   end

   // pll timing and option registers
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         phase_q <= RST_PHASE;
         pre_hold_q <= RST_PRE_HOLD;
         post_hold_q <= RST_POST_HOLD;
         pll_opt_q <= RST_PLL_OPT;
      end else if (wr_stb) begin
         if (idx == IDX_PHASE) begin
            phase_q <= {2'b00, wbyte[HI6_MSB:0]};
         end else if (idx == IDX_PRE_HOLD) begin
            pre_hold_q <= wbyte;
         end else if (idx == IDX_POST_HOLD) begin
            post_hold_q <= wbyte;
         end else if (idx == IDX_PLL_OPT) begin
            pll_opt_q <= {3'b000, wbyte[4:0]};
         end
      end
   end

   // clamp and front-end configuration registers
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         clamp_hi_q <= RST_CLAMP_ST_HI;
         clamp_lo_q <= RST_CLAMP_ST_LO;
         clamp_width_q <= RST_CLAMP_WIDTH;
         comp_ctrl_q <= RST_COMP_CTRL;
         input_cfg_q <= RST_INPUT_CFG;
      end else if (wr_stb) begin
         if (idx == IDX_CLAMP_ST_HI) begin
            clamp_hi_q <= {2'b00, wbyte[HI6_MSB:0]};
         end else if (idx == IDX_CLAMP_ST_LO) begin
            clamp_lo_q <= wbyte;
         end else if (idx == IDX_CLAMP_WIDTH) begin
            clamp_width_q <= wbyte;
         end else if (idx == IDX_COMP_CTRL) begin
            comp_ctrl_q <= {1'b0, wbyte[6:0]};
         end else if (idx == IDX_INPUT_CFG) begin
            input_cfg_q <= {7'h00, wbyte[0]};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers; the first stage feeds only the second
   sync_pins_t pins_meta_q;    // first stage
   sync_pins_t pins_q;         // second stage, safe to use
   logic hsync_d1_q;           // hsync one cycle back
   logic vsync_d1_q;           // vsync one cycle back

   // two flops on every pin, then edge history
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pins_meta_q <= '0;
         pins_q <= '0;
         hsync_d1_q <= 1'b0;
         vsync_d1_q <= 1'b0;
      end else begin
         pins_meta_q <= pins_i;
         pins_q <= pins_meta_q;
         hsync_d1_q <= pins_q.hsync;
         vsync_d1_q <= pins_q.vsync;
      end
   end

   logic hs_lead;    // hsync leading edge
   logic hs_trail;   // hsync trailing edge
   logic vs_lead;    // vsync start
   logic vs_trail;   // vsync end
   assign hs_lead = pins_q.hsync && !hsync_d1_q;
   assign hs_trail = !pins_q.hsync && hsync_d1_q;
   assign vs_lead = pins_q.vsync && !vsync_d1_q;
   assign vs_trail = !pins_q.vsync && vsync_d1_q;

   ////////////////////////////////////////////////////////////////////////////
   // internal hold window: the frame length is measured, so the pre-hold
   // start can be predicted; the first frame after reset has no prediction
   logic [FRAME_W-1:0] line_cnt_q;     // lines since last vsync start
   logic [FRAME_W-1:0] frame_lines_q;  // lines in the previous frame
   logic [7:0] post_cnt_q;             // lines left in post hold
   logic post_hold_q_act;              // post-hold still running
   logic pre_win;                      // inside pre-hold lines
   logic int_hold;                     // internal hold window
   logic ext_hold;                     // external hold, polarity applied
   logic hold;                         // selected hold

   // count lines and measure frame length
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         line_cnt_q <= '0;
         frame_lines_q <= '0;
      end else if (vs_lead) begin
         frame_lines_q <= line_cnt_q;
         line_cnt_q <= '0;
      end else if (hs_lead && line_cnt_q != '1) begin
         line_cnt_q <= line_cnt_q + 1'b1;
      end
   end

   // post hold counts lines after vsync ends
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         post_cnt_q <= '0;
         post_hold_q_act <= 1'b0;
      end else if (vs_trail) begin
         post_cnt_q <= post_hold_q;                  // R7
         post_hold_q_act <= post_hold_q != 8'h00;
      end else if (hs_lead && post_hold_q_act) begin
         post_cnt_q <= post_cnt_q - 1'b1;
         post_hold_q_act <= post_cnt_q > 8'h01;      // R7
      end
   end

   assign pre_win = frame_lines_q != '0 &&
                    FRAME_W'(line_cnt_q + FRAME_W'(pre_hold_q)) >= frame_lines_q;   // R6
   assign int_hold = pre_win || pins_q.vsync || post_hold_q_act;
   assign ext_hold = pins_q.ext_hold ^ pll_opt_q[OPT_HOLD_POL];              // R11
   assign hold = pll_opt_q[OPT_HOLD_EXT] ? ext_hold : int_hold;             // R10

   ////////////////////////////////////////////////////////////////////////////
   // pll reference and clock options
   logic ref_edge;   // selected hsync edge
   assign ref_edge = pll_opt_q[OPT_LOCK_EDGE] ? hs_lead : hs_trail;         // R8

   // reference pulses are withheld while holding
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pll_ref_o <= 1'b0;
         pll_hold_o <= 1'b0;
      end else begin
         pll_ref_o <= ref_edge && !hold;   // R17
         pll_hold_o <= hold;               // R17
      end
   end

   // clock selection outputs
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         clock_invert_o <= 1'b0;
         external_pixel_clock_sel_o <= 1'b0;
      end else begin
         clock_invert_o <= pll_opt_q[OPT_CLOCK_INVERT_INPUT_EN] && pins_q.clk_inv;   // R9
         external_pixel_clock_sel_o <= pll_opt_q[OPT_EXT_CLK];          // R12
      end
   end

   assign line_length_o = len_act_q;                  // R4
   assign sample_phase_o = phase_q[HI6_MSB:0];        // R5

   ////////////////////////////////////////////////////////////////////////////
   // clamp window, counted in pixels from the raw hsync trailing edge;
   // one clock counts as one pixel
   logic [LINE_W-1:0] pix_cnt_q;   // pixels since trailing edge
   logic [7:0] clamp_left_q;       // clamp pixels left
   logic at_start;                 // start pixel reached

   assign at_start = pix_cnt_q == join14(clamp_hi_q, clamp_lo_q);   // R13

   // pixel counter restarts at every trailing edge
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pix_cnt_q <= '0;
      end else if (hs_trail) begin
         pix_cnt_q <= '0;
      end else if (pix_cnt_q != '1) begin
         pix_cnt_q <= pix_cnt_q + 1'b1;
      end
   end

   // clamp runs for the programmed width, ac-coupled only
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         clamp_left_q <= '0;
         clamp_connect_o <= 1'b0;
         black_avg_start_o <= 1'b0;
      end else begin
         black_avg_start_o <= at_start && !hs_trail;   // R13
         if (hs_trail) begin
            clamp_left_q <= '0;
            clamp_connect_o <= 1'b0;
         end else if (at_start && !input_cfg_q[CFG_DC_COUPLED] &&
                      clamp_width_q != 8'h00) begin    // R14 R15
            clamp_left_q <= clamp_width_q - 1'b1;
            clamp_connect_o <= 1'b1;
         end else if (clamp_left_q != 8'h00) begin
            clamp_left_q <= clamp_left_q - 1'b1;
         end else begin
            clamp_connect_o <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // offset routing: dac or digital adder, same delay either way
   logic comp_on;   // automatic compensation enabled
   assign comp_on = !comp_ctrl_q[COMP_DISABLE];

   // one register stage on the sample path
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         for (int c = 0; c < 3; c++) begin
            sample_o[c] <= '0;
            offset_dac_o[c] <= RST_OFS_HI;
         end
         offset_digital_o <= 1'b0;
      end else begin
         offset_digital_o <= comp_on;
         for (int c = 0; c < 3; c++) begin
            // word minus 0x200 is the signed offset; mid word adds zero
            if (comp_on) begin
               sample_o[c] <= 10'(sample_i[c] + ofs_word(ofs_hi_q[c], ofs_lo_q[c])
                                - OFS_ZERO);   // R3 R16
               offset_dac_o[c] <= RST_OFS_HI;  // R16
            end else begin
               sample_o[c] <= sample_i[c];
               offset_dac_o[c] <= ofs_hi_q[c];  // R2
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read mux
   logic [7:0] rd_byte;   // selected register
   always_comb begin
      rd_byte = 8'h00;
      if (idx == IDX_RED_OFS_HI) begin
         rd_byte = ofs_hi_q[0];
      end else if (idx == IDX_RED_OFS_LO) begin
         rd_byte = ofs_lo_q[0];
      end else if (idx == IDX_GRN_OFS_HI) begin
         rd_byte = ofs_hi_q[1];
      end else if (idx == IDX_GRN_OFS_LO) begin
         rd_byte = ofs_lo_q[1];
      end else if (idx == IDX_BLU_OFS_HI) begin
         rd_byte = ofs_hi_q[2];
      end else if (idx == IDX_BLU_OFS_LO) begin
         rd_byte = ofs_lo_q[2];
      end else if (idx == IDX_LINE_LEN_HI) begin
         rd_byte = len_hi_q;
      end else if (idx == IDX_LINE_LEN_LO) begin
         rd_byte = len_lo_q;
      end else if (idx == IDX_PHASE) begin
         rd_byte = phase_q;
      end else if (idx == IDX_PRE_HOLD) begin
         rd_byte = pre_hold_q;
      end else if (idx == IDX_POST_HOLD) begin
         rd_byte = post_hold_q;
      end else if (idx == IDX_PLL_OPT) begin
         rd_byte = pll_opt_q;
      end else if (idx == IDX_CLAMP_ST_HI) begin
         rd_byte = clamp_hi_q;
      end else if (idx == IDX_CLAMP_ST_LO) begin
         rd_byte = clamp_lo_q;
      end else if (idx == IDX_CLAMP_WIDTH) begin
         rd_byte = clamp_width_q;
      end else if (idx == IDX_COMP_CTRL) begin
         rd_byte = comp_ctrl_q;
      end else if (idx == IDX_INPUT_CFG) begin
         rd_byte = input_cfg_q;
      end else if (idx == IDX_STATUS) begin
         // live block state
         rd_byte = {4'h0, clamp_connect_o, pins_q.vsync, post_hold_q_act, pll_hold_o};
      end
   end

   // read data is registered with the ack
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wb_dat_o <= '0;
      end else if (wb_cyc_i && wb_stb_i && !ack_q && !wb_we_i) begin
         wb_dat_o <= {24'h000000, rd_byte};
      end
   end
endmodule

// file: src/afe_cfg_pkg.sv
package afe_cfg_pkg;
   // register indices; byte address on the bus is four times the index
   localparam logic [7:0] IDX_RED_OFS_HI = 8'h18;
   localparam logic [7:0] IDX_RED_OFS_LO = 8'h19;
   localparam logic [7:0] IDX_GRN_OFS_HI = 8'h1a;
   localparam logic [7:0] IDX_GRN_OFS_LO = 8'h1b;
   localparam logic [7:0] IDX_BLU_OFS_HI = 8'h1c;
   localparam logic [7:0] IDX_BLU_OFS_LO = 8'h1d;
   localparam logic [7:0] IDX_LINE_LEN_HI = 8'h1e;
   localparam logic [7:0] IDX_LINE_LEN_LO = 8'h1f;
   localparam logic [7:0] IDX_PHASE = 8'h20;
   localparam logic [7:0] IDX_PRE_HOLD = 8'h21;
   localparam logic [7:0] IDX_POST_HOLD = 8'h22;
   localparam logic [7:0] IDX_PLL_OPT = 8'h23;
   localparam logic [7:0] IDX_CLAMP_ST_HI = 8'h24;
   localparam logic [7:0] IDX_CLAMP_ST_LO = 8'h25;
   localparam logic [7:0] IDX_CLAMP_WIDTH = 8'h26;
   localparam logic [7:0] IDX_COMP_CTRL = 8'h27;
   localparam logic [7:0] IDX_INPUT_CFG = 8'h30;
   localparam logic [7:0] IDX_STATUS = 8'h31;

   // reset values
   localparam logic [7:0] RST_OFS_HI = 8'h80;
   localparam logic [7:0] RST_OFS_LO = 8'h00;
   localparam logic [7:0] RST_LINE_LEN_HI = 8'h06;
   localparam logic [7:0] RST_LINE_LEN_LO = 8'h98;
   localparam logic [7:0] RST_PHASE = 8'h00;
   localparam logic [7:0] RST_PRE_HOLD = 8'h04;
   localparam logic [7:0] RST_POST_HOLD = 8'h04;
   localparam logic [7:0] RST_PLL_OPT = 8'h00;
   localparam logic [7:0] RST_CLAMP_ST_HI = 8'h00;
   localparam logic [7:0] RST_CLAMP_ST_LO = 8'h02;
   localparam logic [7:0] RST_CLAMP_WIDTH = 8'h10;
   localparam logic [7:0] RST_COMP_CTRL = 8'h40;
   localparam logic [7:0] RST_INPUT_CFG = 8'h00;

   // field positions
   localparam int OFS_LO_MSB = 7;         // two low offset bits sit in 7:6
   localparam int OFS_LO_LSB = 6;
   localparam int HI6_MSB = 5;            // six-bit high halves and phase
   localparam int OPT_LOCK_EDGE = 0;
   localparam int OPT_CLOCK_INVERT_INPUT_EN = 1;
   localparam int OPT_HOLD_EXT = 2;
   localparam int OPT_HOLD_POL = 3;
   localparam int OPT_EXT_CLK = 4;
   localparam int COMP_DISABLE = 0;
   localparam int CFG_DC_COUPLED = 0;

   // digital offset zero point of a 10-bit word
   localparam logic [9:0] OFS_ZERO = 10'h200;
   // phase step in parts per million of a pixel period (64 steps)
   localparam int PHASE_STEP_PPM = 15625;

   // pins arriving from outside the clock domain
   typedef struct packed {
      logic hsync;      // raw horizontal sync, active high
      logic vsync;      // vertical sync, active high
      logic ext_hold;   // external pll hold signal
      logic clk_inv;    // clock inversion request pin
   } sync_pins_t;

   // per-channel offset word
   typedef struct packed {
      logic [7:0] hi;
      logic [1:0] lo;
   } offset_word_t;
endpackage

// file: tb/afe_cfg_assertions.sv
`timescale 1ns/1ps
module afe_cfg_checker
   import afe_cfg_pkg::*;
#(
   parameter int LINE_W = 14   // line length width
) (
   input wire logic clk_sys,                   // clock
   input wire logic rst_n,                     // reset
   input wire logic wb_cyc_i,                  // cycle
   input wire logic wb_stb_i,                  // strobe
   input wire logic wb_we_i,                   // write
   input wire logic [9:0] wb_adr_i,            // address
   input wire logic [3:0] wb_sel_i,            // selects
   input wire logic wb_ack_o,                  // ack
   input wire logic [7:0] offset_dac_o [3],    // dac codes
   input wire logic offset_digital_o,          // digital offset
   input wire logic [LINE_W-1:0] line_length_o, // line length
   input wire logic [5:0] sample_phase_o,      // phase
   input wire logic pll_hold_o,                // hold
   input wire logic pll_ref_o,                 // ref pulse
   input wire logic external_pixel_clock_sel_o, // clock source
   input wire logic clamp_connect_o            // clamp
);
   // a write request as the slave sees it; sel[0] gates the low byte
   wire logic wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0];
   wire logic [7:0] idx = wb_adr_i[9:2];
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not acknowledged next cycle");
   a_len_low_only: assert property ($changed(line_length_o) |-> $fell(wb_ack_o) && $past(wr && idx == IDX_LINE_LEN_LO))
      else $error("line length moved without low write");
   a_phase_write: assert property ($changed(sample_phase_o) |-> $past(wr && idx == IDX_PHASE))
      else $error("phase moved without write");
   a_clk_src_write: assert property ($changed(external_pixel_clock_sel_o) |-> $past(wr && idx == IDX_PLL_OPT, 2))
      else $error("clock source moved without write");
   a_dac_mid_digital: assert property (offset_digital_o && $past(offset_digital_o) |-> offset_dac_o[0] == 8'h80 && offset_dac_o[2] == 8'h80)
      else $error("dac not parked while offset is digital");
   a_ref_quiet_hold: assert property (pll_hold_o && $past(pll_hold_o) |-> !pll_ref_o)
      else $error("reference pulse during hold");
   a_ref_pulse: assert property (pll_ref_o |=> !pll_ref_o)
      else $error("reference pulse longer than one cycle");
   c_len_write: cover property ($changed(line_length_o));
   c_hold: cover property ($rose(pll_hold_o));
   c_clamp: cover property ($rose(clamp_connect_o));
endmodule
////////////////////////////////////////////////////////////
bind afe_pll_clamp_config_regs afe_cfg_checker #(.LINE_W(LINE_W)) u_chk (.*);

// file: tb/host_bus_master.sv
`timescale 1ns/1ps
// host side of the register bus: one classic cycle per call
module host_bus_master (
   input wire logic clk_sys,          // clock
   input wire logic wb_ack_o,         // ack
   input wire logic [31:0] wb_dat_o,  // read data
   output logic wb_cyc_i,             // cycle
   output logic wb_stb_i,             // strobe
   output logic wb_we_i,              // write
   output logic [9:0] wb_adr_i,       // address
   output logic [3:0] wb_sel_i,       // selects
   output logic [31:0] wb_dat_i       // write data
);
   logic ack_s;
   logic [7:0] dat_s;
   initial {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
   // sample mid-cycle, free of update races
   always @(negedge clk_sys) {ack_s, dat_s} = {wb_ack_o, wb_dat_o[7:0]};
   task automatic xfer(input logic we, input logic [7:0] idx, input logic [7:0] wd,
                       output logic [7:0] rd);
      @(posedge clk_sys);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} <= {2'b11, we, 4'h1};
      {wb_adr_i, wb_dat_i} <= {idx, 2'b00, 24'h000000, wd};
      do @(posedge clk_sys); while (ack_s !== 1'b1);
      rd = dat_s;
      // released data flips so stale data never looks live
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_dat_i} <= {3'b000, ~wb_dat_i};
      @(negedge clk_sys);
   endtask
endmodule

// file: tb/afe_pll_clamp_config_regs_test.sv
`timescale 1ns/1ps
module afe_pll_clamp_config_regs_test;
   import afe_cfg_pkg::*;
   logic clk_sys, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, offset_digital_o;
   logic pll_hold_o, pll_ref_o, clock_invert_o, external_pixel_clock_sel_o;
   logic clamp_connect_o, black_avg_start_o;
   logic [9:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o;
   logic [9:0] sample_i [3], sample_o [3];
   logic [7:0] offset_dac_o [3];
   logic [13:0] line_length_o;
   logic [5:0] sample_phase_o;
   sync_pins_t pins_i;
   int fail_count = 0, checks_done = 0, refs = 0, clamps = 0, starts = 0, cycles = 0;
   logic [7:0] rv [15] = '{8'h80, 8'h00, 8'h80, 8'h00, 8'h80, 8'h00, 8'h06, 8'h98,
                           8'h00, 8'h04, 8'h04, 8'h00, 8'h00, 8'h02, 8'h10};
   afe_pll_clamp_config_regs dut (.*);
   host_bus_master host (.*);
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // pulse counters; the bench clears them between scenarios
   always @(posedge clk_sys) refs <= refs + (pll_ref_o === 1'b1);
   always @(posedge clk_sys) clamps <= clamps + (clamp_connect_o === 1'b1);
   always @(posedge clk_sys) starts <= starts + (black_avg_start_o === 1'b1);
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fail_count++;
         print_verdict();
      end
   end
   ////////////////////////////////////////////////////////////
   task automatic print_verdict;
      $display("checks %0d errors %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] v);
      logic [7:0] d;
      host.xfer(1'b1, idx, v, d);
   endtask
   task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
      logic [7:0] d;
      host.xfer(1'b0, idx, 8'h00, d);
      chk(d, exp);
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clk_sys);
      @(negedge clk_sys);
   endtask
   task automatic pin(input int b, input logic v, input int n);
      @(posedge clk_sys) pins_i[b] <= v;
      settle(n);
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      rst_n = 1'b0;
      pins_i = '0;
      sample_i = '{default: 10'h100};
      repeat (12) @(posedge clk_sys);
      rst_n <= 1'b1;
      chk(line_length_o, 14'h0698);
      for (int i = 0; i < 15; i++) rdchk(8'h18 + 8'(i), rv[i]);
      for (int i = 0; i < 15; i++) wr(8'h18 + 8'(i), 8'ha5);
      for (int i = 0; i < 15; i++)
         rdchk(8'h18 + 8'(i), (i < 6 && i % 2) ? 8'h80 : i inside {6, 8, 12} ? 8'h25 :
               i == 11 ? 8'h05 : 8'ha5);
      wr(8'h10, 8'hff);
      rdchk(8'h10, 8'h00);
      wr(IDX_LINE_LEN_HI, 8'h2a);
      chk(line_length_o, 14'h25a5);
      wr(IDX_LINE_LEN_LO, 8'h34);
      chk(line_length_o, 14'h2a34);
      wr(IDX_PHASE, 8'h3f);
      chk(sample_phase_o, 6'h3f);
      for (int e = 0; e < 2; e++) begin
         wr(IDX_PLL_OPT, 8'(e));
         refs = 0;
         pin(3, 1'b1, 8);
         chk(refs, e);
         pin(3, 1'b0, 8);
         chk(refs, 1);
      end
      wr(IDX_CLAMP_ST_HI, 8'h00);
      wr(IDX_CLAMP_ST_LO, 8'h03);
      foreach (rv[w]) if (w inside {0, 1, 4}) begin
         wr(IDX_CLAMP_WIDTH, 8'(w));
         pin(3, 1'b1, 6);
         // the trailing edge first ends any window left running
         pin(3, 1'b0, 3);
         {clamps, starts} = '0;
         settle(17);
         chk(clamps, w);
         chk(starts, 1);
      end
      wr(IDX_PRE_HOLD, 8'h00);
      wr(IDX_POST_HOLD, 8'h02);
      pin(2, 1'b1, 6);
      chk(pll_hold_o, 1'b1);
      refs = 0;
      pin(3, 1'b1, 6);
      pin(3, 1'b0, 6);
      chk(refs, 0);
      pin(2, 1'b0, 6);
      chk(pll_hold_o, 1'b1);
      pin(3, 1'b1, 6);
      pin(3, 1'b0, 6);
      chk(pll_hold_o, 1'b1);
      for (int k = 0; k < 2; k++) begin
         pin(3, 1'b1, 6);
         pin(3, 1'b0, 6);
      end
      chk(pll_hold_o, 1'b0);
      wr(IDX_PLL_OPT, 8'h04);
      pin(1, 1'b1, 6);
      chk(pll_hold_o, 1'b1);
      wr(IDX_PLL_OPT, 8'h0c);
      settle(4);
      chk(pll_hold_o, 1'b0);
      pin(1, 1'b0, 6);
      chk(pll_hold_o, 1'b1);
      wr(IDX_PLL_OPT, 8'h12);
      pin(0, 1'b1, 6);
      chk(clock_invert_o, 1'b1);
      chk(external_pixel_clock_sel_o, 1'b1);
      wr(IDX_PLL_OPT, 8'h10);
      settle(4);
      chk(clock_invert_o, 1'b0);
      wr(IDX_COMP_CTRL, 8'h41);
      wr(IDX_RED_OFS_HI, 8'h37);
      settle(3);
      chk(offset_dac_o[0], 8'h37);
      chk(offset_digital_o, 1'b0);
      chk(sample_o[0], 10'h100);
      wr(IDX_COMP_CTRL, 8'h40);
      wr(IDX_RED_OFS_HI, 8'h81);
      wr(IDX_RED_OFS_LO, 8'h40);
      settle(3);
      chk(sample_o[0], 10'h105);
      chk(offset_dac_o[0], 8'h80);
      wr(IDX_RED_OFS_HI, 8'h80);
      wr(IDX_RED_OFS_LO, 8'h00);
      settle(3);
      chk(sample_o[0], 10'h100);
      print_verdict();
   end
endmodule
